// ==== rtl/ipc_carrier_ctrl.sv ====
/*
  Carrier frequency, modulation scheme, overmodulation limit, bus voltage
  compensation, braking chopper, phase swap, fan and trial timer control.
  Assumes synchronous inputs on clk and a register master that never
  issues read and write strobes in the same cycle.
*/
// Our own choices: strobed register access and the register offsets.
// Overview of operation
// - Above upper point use high-speed carrier.
// - Below lower point use low-speed carrier.
// - Adjust select bit zero enables adjustment.
// - Carrier settings clamp to 1.0-15.0 kHz.
// - Four modulation schemes, space vector default.
// - Random scheme dithers carrier for broadband noise.
// - Discontinuous mode at or above threshold, 10-100 percent.
// - Modulation index limited to 100-110 percent.
// - Compensate modulation for bus voltage when enabled.
// - Brake chopper off, on, or ramp only.
// - Phase swap exchanges V and W drives.
// - Fan runs by run, always, temperature.
// - Duty type selects constant or light load.
// - Trial time elapse stops output, raises fault.
`timescale 1ns/1ps
module ipc_carrier_ctrl
  import ipc_pkg::*;
#(
  parameter int SEC_TICKS = SEC_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output      logic [31:0] reg_rdata,
  input  wire logic [15:0] out_freq,
  input  wire logic [7:0]  mod_index,
  input  wire logic [11:0] bus_voltage,
  input  wire logic [11:0] drive_temp,
  input  wire logic        drive_running,
  input  wire logic        ramp_stop_active,
  input  wire logic        brake_request,
  input  wire logic        brake_fitted,
  input  wire ipc_phase_t  phase_in,
  output      logic [7:0]  carrier_freq,
  output      logic        dpwm_active,
  output      logic [7:0]  mod_cmd,
  output      ipc_phase_t  phase_out,
  output      logic        brake_gate,
  output      logic        fan_on,
  output      logic        duty_light,
  output      logic        output_stop,
  output      logic        trial_expired_fault,
  output      logic        irq
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Range clamp shared by the carrier, switch point, threshold, limit and trial writes.
  function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (v < {16'h0000, lo}) begin
      r = lo;
    end else if (v > {16'h0000, hi}) begin
      r = hi;
    end
    return r;
  endfunction

  typedef enum logic [1:0] {TR_IDLE, TR_COUNT, TR_EXPIRED} ipc_trial_t;
  ipc_cfg_t            cfg_reg;
  logic [IRQ_W-1:0]    int_st_reg;
  logic [IRQ_W-1:0]    int_msk_reg;
  logic [31:0]         rdata_reg;
  logic [7:0]          carrier_reg;
  logic                dpwm_reg;
  logic [7:0]          mod_reg;
  ipc_phase_t          phase_reg;
  logic                brake_reg;
  logic                fan_reg;
  logic [15:0]         lfsr_reg;
  logic [23:0]         div_reg;
  logic [15:0]         trial_cnt_reg;
  ipc_trial_t          trial_reg;
  ipc_trial_t          trial_next;

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  wire wr_intst = reg_wr && (reg_addr == A_INTST);
  // Out-of-range settings are clamped rather than refused.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= '{adj_en: 1'b0, lo_car: CAR_RST[7:0], hi_car: CAR_RST[7:0], lo_pt: LOPT_RST, hi_pt: HIPT_RST,
                   scheme: SCH_SVPWM, dpwm_thr: DPWM_RST[7:0], mod_lim: LIM_RST[7:0], avr_en: 1'b1,
                   brake: BRK_ON, swap: 1'b0, fan: FAN_RUN, duty: 1'b0, trial: 16'h0000,
                   fan_tmp: FANTMP_RST[11:0], bus_nom: BUSNOM_RST[11:0], base_car: CAR_RST[7:0]};
      int_msk_reg <= '0;
    end else if (reg_wr) begin
      if (reg_addr == A_ADJ) begin
        cfg_reg.adj_en <= reg_wdata[0];
      end else if (reg_addr == A_LOCAR) begin
        cfg_reg.lo_car <= 8'(clamp16(reg_wdata, CAR_MIN, CAR_MAX));
      end else if (reg_addr == A_HICAR) begin
        cfg_reg.hi_car <= 8'(clamp16(reg_wdata, CAR_MIN, CAR_MAX));
      end else if (reg_addr == A_LOPT) begin
        cfg_reg.lo_pt <= clamp16(reg_wdata, PT_MIN, PT_MAX);
      end else if (reg_addr == A_HIPT) begin
        cfg_reg.hi_pt <= clamp16(reg_wdata, PT_MIN, PT_MAX);
      end else if (reg_addr == A_SCHEME) begin
        cfg_reg.scheme <= ipc_scheme_t'(reg_wdata[1:0]);
      end else if (reg_addr == A_DPWM) begin
        cfg_reg.dpwm_thr <= 8'(clamp16(reg_wdata, DPWM_MIN, DPWM_MAX));
      end else if (reg_addr == A_LIMIT) begin
        cfg_reg.mod_lim <= 8'(clamp16(reg_wdata, LIM_MIN, LIM_MAX));
      end else if (reg_addr == A_AVR) begin
        cfg_reg.avr_en <= reg_wdata[0];
      end else if (reg_addr == A_BRAKE) begin
        cfg_reg.brake <= (reg_wdata[1:0] == BRK_RSVD) ? BRK_ON : ipc_brake_t'(reg_wdata[1:0]);
      end else if (reg_addr == A_SWAP) begin
        cfg_reg.swap <= reg_wdata[0];
      end else if (reg_addr == A_FAN) begin
        cfg_reg.fan <= (reg_wdata[1:0] == FAN_RSVD) ? FAN_RUN : ipc_fan_t'(reg_wdata[1:0]);
      end else if (reg_addr == A_DUTY) begin
        cfg_reg.duty <= reg_wdata[0];
      end else if (reg_addr == A_TRIAL) begin
        cfg_reg.trial <= clamp16(reg_wdata, 16'h0000, TRIAL_MAX);
      end else if (reg_addr == A_FANTMP) begin
        cfg_reg.fan_tmp <= reg_wdata[11:0];
      end else if (reg_addr == A_BUSNOM) begin
        cfg_reg.bus_nom <= reg_wdata[11:0];
      end else if (reg_addr == A_BASE) begin
        cfg_reg.base_car <= 8'(clamp16(reg_wdata, CAR_MIN, CAR_MAX));
      end else if (reg_addr == A_INTMSK) begin
        int_msk_reg <= reg_wdata[IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Carrier selection by output frequency
  // ----------------------------------------------------------------------
  // A span of zero would divide by zero, so the high or low branch covers it.
  wire              above_hi  = out_freq > cfg_reg.hi_pt;
  wire              below_lo  = (out_freq < cfg_reg.lo_pt) || (cfg_reg.hi_pt <= cfg_reg.lo_pt);
  wire [16:0]       span      = {1'b0, cfg_reg.hi_pt} - {1'b0, cfg_reg.lo_pt};
  wire [16:0]       f_off     = {1'b0, out_freq} - {1'b0, cfg_reg.lo_pt};
  wire signed [9:0] car_delta = $signed({2'b00, cfg_reg.hi_car}) - $signed({2'b00, cfg_reg.lo_car});
  wire signed [27:0] prod     = car_delta * $signed({1'b0, f_off});
  wire signed [27:0] quot     = prod / $signed({11'h000, span});
  wire [7:0]        interp    = cfg_reg.lo_car + quot[7:0];
  wire [7:0]        car_sel   = !cfg_reg.adj_en ? cfg_reg.base_car :
                                above_hi ? cfg_reg.hi_car :
                                below_lo ? cfg_reg.lo_car :
                                interp;

  // Random scheme spreads the carrier by up to eight tenths of a kHz down and seven tenths up.
  wire [8:0] dith     = {1'b0, car_sel} + {5'h00, lfsr_reg[3:0]} - {5'h00, LFSR_MID};
  wire [7:0] car_rand = 8'(clamp16({23'h000000, dith}, CAR_MIN, CAR_MAX));
  wire [7:0] car_fin  = (cfg_reg.scheme == SCH_RANDOM) ? car_rand : car_sel;

  // ----------------------------------------------------------------------
  // Modulation limit and bus compensation
  // ----------------------------------------------------------------------
  // A collapsed bus reading leaves the index uncompensated instead of dividing by zero.
  wire [19:0] comp_raw = ({12'h000, mod_index} * {8'h00, cfg_reg.bus_nom}) / {8'h00, bus_voltage};
  wire [19:0] comp     = (cfg_reg.avr_en && bus_voltage != 12'h000) ? comp_raw : {12'h000, mod_index};
  wire        clamp_ev = comp > {12'h000, cfg_reg.mod_lim};
  wire [7:0]  mod_lim  = clamp_ev ? cfg_reg.mod_lim : comp[7:0];
  wire        dpwm_sel = (cfg_reg.scheme == SCH_DPWM) && (mod_lim >= cfg_reg.dpwm_thr);

  // ----------------------------------------------------------------------
  // Power stage steering
  // ----------------------------------------------------------------------
  wire        stop_now  = (trial_reg == TR_EXPIRED);
  wire ipc_phase_t ph_swap = cfg_reg.swap ? {phase_in.v, phase_in.w, phase_in.u} : phase_in;
  wire brk_mode = (cfg_reg.brake == BRK_ON) || ((cfg_reg.brake == BRK_RAMP) && ramp_stop_active);
  wire brk_sel  = brake_fitted && brake_request && brk_mode;
  wire fan_sel  = (cfg_reg.fan == FAN_ALWAYS) ||
                  ((cfg_reg.fan == FAN_RUN) && drive_running) ||
                  ((cfg_reg.fan == FAN_TEMP) && (drive_temp >= cfg_reg.fan_tmp));

  // Output stage flops; the stopped drive forces the phase switches and modulation off, but not the brake gate.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      carrier_reg <= CAR_RST[7:0];
      dpwm_reg    <= 1'b0;
      mod_reg     <= 8'h00;
      phase_reg   <= '0;
      brake_reg   <= 1'b0;
      fan_reg     <= 1'b0;
      lfsr_reg    <= LFSR_SEED;
    end else begin
      carrier_reg <= car_fin;
      dpwm_reg    <= dpwm_sel;
      mod_reg     <= stop_now ? 8'h00 : mod_lim;
      phase_reg   <= stop_now ? '0 : ph_swap;
      brake_reg   <= brk_sel;
      fan_reg     <= fan_sel;
      lfsr_reg    <= lfsr_reg[0] ? ((lfsr_reg >> 1) ^ LFSR_TAPS) : (lfsr_reg >> 1);
    end
  end

  // ----------------------------------------------------------------------
  // Trial timer
  // ----------------------------------------------------------------------
  wire sec_tick = (div_reg == 24'(SEC_TICKS - 1));

  // Writing zero is the only way out of the expired state short of reset.
  always_comb begin
    trial_next = trial_reg;
    case (trial_reg)
      TR_IDLE: begin
        if (cfg_reg.trial != 16'h0000) begin
          trial_next = TR_COUNT;
        end
      end
      TR_COUNT: begin
        if (cfg_reg.trial == 16'h0000) begin
          trial_next = TR_IDLE;
        end else if (trial_cnt_reg >= cfg_reg.trial) begin
          trial_next = TR_EXPIRED;
        end
      end
      default: begin
        if (cfg_reg.trial == 16'h0000) begin
          trial_next = TR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      trial_reg     <= TR_IDLE;
      div_reg       <= 24'h000000;
      trial_cnt_reg <= 16'h0000;
    end else begin
      trial_reg     <= trial_next;
      div_reg       <= sec_tick ? 24'h000000 : div_reg + 24'h000001;
      if (trial_reg != TR_COUNT) begin
        trial_cnt_reg <= 16'h0000;
      end else if (sec_tick) begin
        trial_cnt_reg <= trial_cnt_reg + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Interrupts and read port
  // ----------------------------------------------------------------------
  wire [IRQ_W-1:0] events = {clamp_ev, (trial_reg == TR_COUNT) && (trial_next == TR_EXPIRED)};
  wire [IRQ_W-1:0] clr    = wr_intst ? reg_wdata[IRQ_W-1:0] : '0;
  wire [31:0] state_word  = {20'h00000, 1'b0, stop_now, dpwm_reg, 1'b0, carrier_reg};
  wire [31:0] rd_mux      = (reg_addr == A_STATE)  ? state_word :
                            (reg_addr == A_INTST)  ? {30'h00000000, int_st_reg} :
                            (reg_addr == A_INTMSK) ? {30'h00000000, int_msk_reg} :
                            (reg_addr == A_TRIAL)  ? {16'h0000, cfg_reg.trial} :
                            (reg_addr == A_LOCAR)  ? {24'h000000, cfg_reg.lo_car} :
                            (reg_addr == A_HICAR)  ? {24'h000000, cfg_reg.hi_car} :
                            (reg_addr == A_LIMIT)  ? {24'h000000, cfg_reg.mod_lim} :
                            (reg_addr == A_SCHEME) ? {30'h00000000, cfg_reg.scheme} : 32'h00000000;

  // A new event in the clearing cycle survives the clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      int_st_reg <= '0;
      rdata_reg  <= 32'h00000000;
    end else begin
      int_st_reg <= (int_st_reg & ~clr) | events;
      rdata_reg  <= reg_rd ? rd_mux : 32'h00000000;
    end
  end

  assign reg_rdata           = rdata_reg;
  assign carrier_freq        = carrier_reg;
  assign dpwm_active         = dpwm_reg;
  assign mod_cmd             = mod_reg;
  assign phase_out           = phase_reg;
  assign brake_gate          = brake_reg;
  assign fan_on              = fan_reg;
  assign duty_light          = cfg_reg.duty;
  assign output_stop         = stop_now;
  assign trial_expired_fault = stop_now;
  assign irq                 = |(int_st_reg & int_msk_reg);

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_hi_car;
    cfg_reg.adj_en && out_freq > cfg_reg.hi_pt && cfg_reg.scheme != SCH_RANDOM |=> carrier_freq == $past(cfg_reg.hi_car);
  endproperty
  a_hi_car: assert property (p_hi_car) else $error("high carrier not used");

  property p_lo_car;
    cfg_reg.adj_en && out_freq < cfg_reg.lo_pt && cfg_reg.scheme != SCH_RANDOM |=> carrier_freq == $past(cfg_reg.lo_car);
  endproperty
  a_lo_car: assert property (p_lo_car) else $error("low carrier not used");

  property p_car_range;
    carrier_freq >= CAR_MIN[7:0] && carrier_freq <= CAR_MAX[7:0];
  endproperty
  a_car_range: assert property (p_car_range) else $error("carrier out of range");

  property p_mod_lim;
    mod_cmd <= $past(cfg_reg.mod_lim);
  endproperty
  a_mod_lim: assert property (p_mod_lim) else $error("modulation above limit");

  property p_dpwm;
    cfg_reg.scheme != SCH_DPWM |=> !dpwm_active;
  endproperty
  a_dpwm: assert property (p_dpwm) else $error("discontinuous mode outside its scheme");

  property p_swap;
    cfg_reg.swap && !stop_now && !$past(stop_now) |=> phase_out.w == $past(phase_in.v) && phase_out.v == $past(phase_in.w);
  endproperty
  a_swap: assert property (p_swap) else $error("phases not swapped");

  property p_brake_off;
    cfg_reg.brake == BRK_OFF |=> !brake_gate;
  endproperty
  a_brake_off: assert property (p_brake_off) else $error("brake active while disabled");

  property p_fan_always;
    cfg_reg.fan == FAN_ALWAYS ##1 cfg_reg.fan == FAN_ALWAYS |-> fan_on;
  endproperty
  a_fan_always: assert property (p_fan_always) else $error("fan off in forced mode");

  property p_trial_stop;
    trial_expired_fault |=> phase_out == '0 && mod_cmd == 8'h00;
  endproperty
  a_trial_stop: assert property (p_trial_stop) else $error("output not stopped after trial");

endmodule

// ==== rtl/ipc_pkg.sv ====
/*
  Package for the inverter carrier and modulation control block: register
  offsets, reset values, setting ranges, field widths and shared types.
  Assumes a 10 MHz system clock and a plain register port with byte offsets.
*/
package ipc_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ       = 10_000_000;  // System clock rate in Hz.
  localparam int TRIAL_UNIT_S = 1;           // One trial count is one second.
  localparam int SEC_CYCLES   = CLK_HZ * TRIAL_UNIT_S;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses, one aligned word each)
  // ----------------------------------------------------------------------
  localparam logic [7:0] A_ADJ    = 8'h00;  // Carrier adjust select.
  localparam logic [7:0] A_LOCAR  = 8'h04;  // Low-speed carrier, 0.1 kHz.
  localparam logic [7:0] A_HICAR  = 8'h08;  // High-speed carrier, 0.1 kHz.
  localparam logic [7:0] A_LOPT   = 8'h0C;  // Lower switch point, 0.01 Hz.
  localparam logic [7:0] A_HIPT   = 8'h10;  // Upper switch point, 0.01 Hz.
  localparam logic [7:0] A_SCHEME = 8'h14;
  localparam logic [7:0] A_DPWM   = 8'h18;  // Discontinuous threshold, percent.
  localparam logic [7:0] A_LIMIT  = 8'h1C;  // Modulation index limit, percent.
  localparam logic [7:0] A_AVR    = 8'h20;
  localparam logic [7:0] A_BRAKE  = 8'h24;
  localparam logic [7:0] A_SWAP   = 8'h28;
  localparam logic [7:0] A_FAN    = 8'h2C;
  localparam logic [7:0] A_DUTY   = 8'h30;
  localparam logic [7:0] A_TRIAL  = 8'h34;  // Trial time, seconds.
  localparam logic [7:0] A_FANTMP = 8'h38;  // Fan temperature threshold.
  localparam logic [7:0] A_BUSNOM = 8'h3C;  // Nominal bus voltage, V.
  localparam logic [7:0] A_BASE   = 8'h40;  // Fixed carrier, 0.1 kHz.
  localparam logic [7:0] A_STATE  = 8'h44;  // Read only block state.
  localparam logic [7:0] A_INTST  = 8'h48;  // Sticky events, write one to clear.
  localparam logic [7:0] A_INTMSK = 8'h4C;

  // ----------------------------------------------------------------------
  // Ranges and reset values
  // ----------------------------------------------------------------------
  localparam logic [15:0] CAR_MIN    = 16'h000A;  // 1.0 kHz.
  localparam logic [15:0] CAR_MAX    = 16'h0096;  // 15.0 kHz.
  localparam logic [15:0] CAR_RST    = 16'h0028;  // 4.0 kHz.
  localparam logic [15:0] PT_MIN     = 16'h0000;
  localparam logic [15:0] PT_MAX     = 16'hEA60;  // 600.00 Hz.
  localparam logic [15:0] LOPT_RST   = 16'h03E8;  // 10.00 Hz.
  localparam logic [15:0] HIPT_RST   = 16'h1388;  // 50.00 Hz.
  localparam logic [15:0] DPWM_MIN   = 16'h000A;  // 10 %.
  localparam logic [15:0] DPWM_MAX   = 16'h0064;  // 100 %.
  localparam logic [15:0] DPWM_RST   = 16'h001E;  // 30 %.
  localparam logic [15:0] LIM_MIN    = 16'h0064;  // 100 %.
  localparam logic [15:0] LIM_MAX    = 16'h006E;  // 110 %.
  localparam logic [15:0] LIM_RST    = 16'h0069;  // 105 %.
  localparam logic [15:0] BUSNOM_RST = 16'h021C;  // 540 V.
  localparam logic [15:0] FANTMP_RST = 16'h0032;
  localparam logic [15:0] TRIAL_MAX  = 16'hFFFF;
  localparam logic [3:0]  LFSR_MID   = 4'h8;      // Centre of the random spread.
  localparam logic [15:0] LFSR_SEED  = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS  = 16'hB400;

  // Interrupt bit positions.
  localparam int IRQ_TRIAL = 0;
  localparam int IRQ_CLAMP = 1;
  localparam int IRQ_W     = 2;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SCH_SVPWM, SCH_DPWM, SCH_RANDOM, SCH_SPWM} ipc_scheme_t;
  typedef enum logic [1:0] {BRK_OFF, BRK_ON, BRK_RAMP, BRK_RSVD} ipc_brake_t;
  typedef enum logic [1:0] {FAN_RUN, FAN_ALWAYS, FAN_TEMP, FAN_RSVD} ipc_fan_t;

  typedef struct packed {
    logic        adj_en;
    logic [7:0]  lo_car;
    logic [7:0]  hi_car;
    logic [15:0] lo_pt;
    logic [15:0] hi_pt;
    ipc_scheme_t scheme;
    logic [7:0]  dpwm_thr;
    logic [7:0]  mod_lim;
    logic        avr_en;
    ipc_brake_t  brake;
    logic        swap;
    ipc_fan_t    fan;
    logic        duty;
    logic [15:0] trial;
    logic [11:0] fan_tmp;
    logic [11:0] bus_nom;
    logic [7:0]  base_car;
  } ipc_cfg_t;

  // Three phase switch commands, bit 0 U, bit 1 V, bit 2 W.
  typedef struct packed {
    logic w;
    logic v;
    logic u;
  } ipc_phase_t;

endpackage

// ==== tb/ipc_power_model.sv ====
/*
  Behavioural power stage for the carrier control bench: it reports the
  DC bus voltage and the heat-sink temperature. Assumes the bench sets both.
*/
`timescale 1ns/1ps
module ipc_power_model (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [11:0] bus_set,
  input  wire logic [11:0] temp_set,
  output      logic [11:0] bus_voltage,
  output      logic [11:0] drive_temp
);
  // Sensors report one clock late, so the block never sees a same-edge change.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_voltage <= 12'h000;
      drive_temp  <= 12'h000;
    end else begin
      bus_voltage <= bus_set;
      drive_temp  <= temp_set;
    end
  end
endmodule

// ==== tb/testbench.sv ====
/*
  Self-checking bench for ipc_carrier_ctrl beside a power stage model.
  Assumes ipc_pkg and a trial second shortened to SEC cycles.
*/
`timescale 1ns/1ps
module testbench
  import ipc_pkg::*;
;
  localparam int SEC = 20;
  logic        clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_seen = 1'b0;
  logic        run = 1'b0, ramp = 1'b0, fit = 1'b0, breq = 1'b1, dpwm, brake_gate, fan_on, duty, stop, fault, irq;
  logic [7:0]  reg_addr = 8'h00, mod_index = 8'h00, carrier, mod_cmd, prev;
  logic [11:0] bus_set = 12'h000, temp_set = 12'h000, bus_v, temp;
  logic [15:0] out_freq = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h1211, exp_q[$];
  ipc_phase_t  phase_in = 3'h0, phase_out, ph;
  string       name_q[$];
  int          mismatches = 0, compares = 0, n;
  logic [15:0] fq [6] = '{16'h1770, 16'h1389, 16'h01F4, 16'h0BB8, 16'h1388, 16'h07D1};
  logic [7:0]  ce [6] = '{8'h64, 8'h64, 8'h14, 8'h3C, 8'h64, 8'h28};
  logic [1:0]  bm [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h1};
  logic [1:0]  fm [6] = '{2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
  logic [5:0]  hot = 6'h08, fitv = 6'h1F, bexp = 6'h1A, runv = 6'h21, fexp = 6'h2D;

  // 10 MHz clock.
  always #50 clk = ~clk;

  ipc_carrier_ctrl #(.SEC_TICKS(SEC)) u_ipc_carrier_ctrl (
    .clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .out_freq(out_freq),
    .mod_index(mod_index), .bus_voltage(bus_v), .drive_temp(temp), .drive_running(run),
    .ramp_stop_active(ramp), .brake_request(breq), .brake_fitted(fit), .phase_in(phase_in),
    .carrier_freq(carrier), .dpwm_active(dpwm), .mod_cmd(mod_cmd), .phase_out(phase_out),
    .brake_gate(brake_gate), .fan_on(fan_on), .duty_light(duty), .output_stop(stop),
    .trial_expired_fault(fault), .irq(irq));

  ipc_power_model u_ipc_power_model (
    .clk(clk), .arst_n(arst_n), .bus_set(bus_set), .temp_set(temp_set),
    .bus_voltage(bus_v), .drive_temp(temp));

  // ----------------------------------------------------------------------
  // Bus tasks and comparison
  // ----------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clk);
    exp_q.push_back(e);
    name_q.push_back(nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  // Outputs are registered, so a few edges let every change land.
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic end_sim();
    if (mismatches == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so compare there.
  always @(posedge clk) begin
    if (rd_seen) begin
      chk(name_q.pop_front(), exp_q.pop_front(), reg_rdata);
    end
    rd_seen <= reg_rd;
  end

  // A hang is cut short well past the expected run length.
  initial begin
    repeat (6000) @(posedge clk);
    mismatches++;
    end_sim();
  end

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    rd(A_LOCAR, 32'h28, "lo_car");
    rd(A_LIMIT, 32'h69, "limit");
    rd(A_SCHEME, 32'h0, "scheme");
    rd(A_STATE, 32'h28, "state");
    rd(8'h7C, 32'h0, "unmapped");
    wr(A_LOCAR, 32'h5);
    rd(A_LOCAR, 32'hA, "lo_min");
    wr(A_HICAR, 32'hC8);
    rd(A_HICAR, 32'h96, "hi_max");
    wr(A_LOCAR, 32'h14);
    wr(A_HICAR, 32'h64);
    wr(A_ADJ, 32'h1);
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      out_freq <= fq[i];
      settle();
      chk("carrier", 32'(ce[i]), 32'(carrier));
    end
    wr(A_ADJ, 32'h0);
    settle();
    chk("base", 32'h28, 32'(carrier));
    for (int s = 0; s < 4; s++) begin
      wr(A_SCHEME, 32'(s));
      rd(A_SCHEME, 32'(s), "scheme");
    end
    wr(A_SCHEME, 32'h2);
    settle();
    n = 0;
    for (int i = 0; i < 64; i++) begin
      prev = carrier;
      @(posedge clk);
      #1;
      n += 32'(carrier != prev);
      chk("band", 32'h1, 32'(carrier >= 8'h20 && carrier <= 8'h2F));
    end
    chk("spread", 32'h1, 32'(n > 2));
    wr(A_AVR, 32'h0);
    wr(A_SCHEME, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(A_DPWM, i < 2 ? 32'h1E : 32'h5);
      @(posedge clk);
      mod_index <= 8'((i < 2 ? 30 : 10) - i % 2);
      settle();
      chk("dpwm", 32'(i % 2 == 0), 32'(dpwm));
      chk("mod_cmd", 32'(mod_index), 32'(mod_cmd));
    end
    wr(A_LIMIT, 32'h6C);
    rd(A_LIMIT, 32'h6C, "limit");
    wr(A_INTMSK, 32'h2);
    @(posedge clk);
    mod_index <= 8'h78;
    settle();
    chk("limited", 32'h6C, 32'(mod_cmd));
    chk("irq", 32'h1, 32'(irq));
    wr(A_LIMIT, 32'h5A);
    rd(A_LIMIT, 32'h64, "lim_min");
    wr(A_LIMIT, 32'h78);
    rd(A_LIMIT, 32'h6E, "lim_max");
    wr(A_AVR, 32'h1);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      mod_index <= 8'h64;
      bus_set <= i ? 12'h1F4 : 12'h258;
      settle();
      chk("avr", i ? 32'h6C : 32'h5A, 32'(mod_cmd));
    end
    wr(A_INTST, 32'h3);
    rd(A_INTST, 32'h0, "status");
    for (int i = 0; i < 6; i++) begin
      wr(A_BRAKE, 32'(bm[i]));
      wr(A_FAN, 32'(fm[i]));
      @(posedge clk);
      ramp <= hot[i];
      fit <= fitv[i];
      run <= runv[i];
      temp_set <= hot[i] ? 12'h064 : 12'h00A;
      settle();
      chk("brake", 32'(bexp[i]), 32'(brake_gate));
      chk("fan", 32'(fexp[i]), 32'(fan_on));
    end
    @(posedge clk);
    fit <= 1'b1;
    breq <= 1'b0;
    settle();
    chk("brake idle", 32'h0, 32'(brake_gate));
    for (int i = 0; i < 8; i++) begin
      wr(A_SWAP, 32'(i / 4));
      ph = ipc_phase_t'(3'(rnd()));
      @(posedge clk);
      phase_in <= ph;
      mod_index <= 8'(rnd() % 100);
      settle();
      chk("phase", 32'(i < 4 ? 3'(ph) : {ph.v, ph.w, ph.u}), 32'(phase_out));
      chk("comp", 32'(mod_index) * 32'(BUSNOM_RST) / 500, 32'(mod_cmd));
    end
    for (int d = 1; d >= 0; d--) begin
      wr(A_DUTY, 32'(d));
      settle();
      chk("duty", 32'(d), 32'(duty));
    end
    wr(A_SCHEME, 32'h0);
    wr(A_INTMSK, 32'h1);
    wr(A_TRIAL, 32'h2);
    rd(A_TRIAL, 32'h2, "trial");
    n = 0;
    while (stop !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    settle();
    chk("trial time", 32'h1, 32'(n >= SEC - 4 && n <= 3 * SEC));
    chk("fault", 32'h1, 32'(fault));
    chk("stopped", 32'h0, 32'({phase_out, mod_cmd}));
    chk("irq", 32'h1, 32'(irq));
    rd(A_STATE, 32'h428, "state");
    wr(A_INTMSK, 32'h0);
    wr(A_TRIAL, 32'h0);
    wr(A_INTST, 32'h1);
    settle();
    chk("irq off", 32'h0, 32'(irq));
    chk("released", 32'h0, 32'(stop));
    rd(A_INTST, 32'h0, "status");
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(A_LIMIT, 32'h69, "limit reset");
    repeat (3) @(posedge clk);
    end_sim();
  end
endmodule
